/* hdl/pin_mux_cfg.svh */
// Purpose: constants for the general pin multiplexer
// Assumes: 21 general pins, APB register access, 50 MHz mclk
`ifndef PIN_MUX_CFG_SVH
`define PIN_MUX_CFG_SVH
`define NPINS 21
`define REG_DOUT 12'h000
`define REG_DIR 12'h004
`define REG_PULL 12'h008
`define REG_DIN 12'h00C
`define REG_PERIPH 12'h010
`define REG_WAKE_EN 12'h014
`define REG_CTRL 12'h018
`define PULL_RESET 21'h1FFFFF
`define EN_SPI1 0
`define EN_SPI2 1
`define EN_SPI3 2
`define EN_SPI4 3
`define EN_RADIO_RX_CTRL_OUT 4
`define EN_RADIO_TX_CTRL_OUT 5
`define EN_PCNT0 6
`define EN_PCNT1 7
`define EN_UART0 8
`define EN_UART0_FLOW 9
`define EN_UART1 10
`define EN_UART1_FLOW 11
`define EN_DEBUG_LO 12
`define EN_DEBUG_HI 13
`define EN_TIM0_GATE 14
`define EN_TIM0_CAP 15
`define EN_TIM0_PWM 16
`define EN_SLOW_XTAL 17
`define EN_SLOW_CLK 18
`define EN_TIM1_GATE 19
`define EN_TIM2_PWM 20
`define EN_TIM1_CAP 21
`define EN_TIM1_PWM 22
`define EN_ANT_DIV 23
`define EN_AUDIO 24
`define EN_TWO_WIRE 25
`define EN_SLAVE_PORT 26
`define CTRL_SLEEP 0
`define CTRL_SOFT_RESET 1
`endif

/* hdl/pin_mux_pkg.sv */
// Purpose: types for the general pin multiplexer
// Assumes: constants come from pin_mux_cfg.svh
// Notes: per-function enable bits are decoded into per-pin routing
`include "pin_mux_cfg.svh"
package pin_mux_pkg;
  typedef logic [`NPINS-1:0] pin_vec_t;
  // periph-side signals into pin drivers
  typedef struct packed {
    logic spi_sel1, spi_sel2, spi_sel3, spi_sel4;
    logic radio_rx, radio_tx;
    logic uart0_rts, uart0_tx, uart1_rts, uart1_tx;
    logic dbg_tdo;
    logic tim0_pwm, tim1_pwm, tim2_pwm;
    logic xtal_out, ant_div_out, ant_div_en;
    logic two_wire_clk_oe, two_wire_data_oe;
    logic slave_data_out, slave_irq, audio_data_out;
  } periph_out_t;
  // pin-side signals back to peripherals
  typedef struct packed {
    logic pulse_count0, pulse_count1;
    logic uart0_cts, uart0_rx, uart1_cts, uart1_rx;
    logic dbg_tck, dbg_tms, dbg_tdi;
    logic tim0_gate, tim0_cap, tim1_gate, tim1_cap;
    logic xtal_in, slow_clk;
    logic audio_ws, audio_din, audio_sck;
    logic two_wire_clk, two_wire_data;
    logic slave_clk, slave_din, slave_sel;
  } periph_in_t;
  typedef struct packed {
    logic oe;
    logic dout;
  } pin_drive_t;
  typedef struct packed {
    pin_vec_t dout, dir, pull, wake_en, din_s1, din_s2, hold_oe, hold_out;
    logic [26:0] periph_en;
    logic sleep, soft_reset, rst_pin_low, wake;
    logic [31:0] prdata;
    logic pready, pslverr;
    pin_vec_t pin_oe, pin_out;
    periph_in_t pin_to_periph;
  } mux_state_t;
endpackage

/* hdl/pin_mux.sv */
// Purpose: general I/O pins with alternate-function routing and APB registers
// Assumes: one 50 MHz clock mclk, synchronous active-low rst_b
// Notes: pin inputs pass two flops, three on the way to periph_in; routing is combinational from enables, then registered
//
// Register access over APB and the placing of the registers were decided locally.
`timescale 1ns/100ps
`default_nettype none
`include "pin_mux_cfg.svh"
module pin_mux (
  input wire logic mclk,
  input wire logic rst_b,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [`NPINS-1:0] gen_io_pin_in,
  output logic [`NPINS-1:0] gen_io_pin_out,
  output logic [`NPINS-1:0] gen_io_pin_oe,
  output logic [`NPINS-1:0] gen_io_pin_pullup,
  input wire pin_mux_pkg::periph_out_t periph_out,
  output pin_mux_pkg::periph_in_t periph_in,
  input wire logic wake_req_in,
  output logic sleep_active,
  output logic wake_event,
  input wire logic reset_pin_low_in,
  output logic reset_pin_low_oe
);
  pin_mux_pkg::mux_state_t s, next_s;
  pin_mux_pkg::pin_drive_t drv [`NPINS];
  logic [26:0] en;
  logic access, wr;

  function automatic logic bitat(input logic [26:0] v, input int idx);
    bitat = v[idx];
  endfunction

  assign en = s.periph_en;
  assign access = psel && penable;
  assign wr = access && pwrite;

  // per-pin alternate routing; first matching case wins
  always_comb begin
    for (int i = 0; i < `NPINS; i++) begin
      drv[i].oe = s.dir[i];
      drv[i].dout = s.dout[i];
    end
    if (bitat(en, `EN_SPI1)) begin
      drv[0] = '{1'b1, periph_out.spi_sel1};
    end
    if (bitat(en, `EN_SPI2)) begin
      drv[1] = '{1'b1, periph_out.spi_sel2};
    end else if (bitat(en, `EN_PCNT0)) begin
      drv[1] = '{1'b0, 1'b0};
    end
    if (bitat(en, `EN_SPI3)) begin
      drv[2] = '{1'b1, periph_out.spi_sel3};
    end else if (bitat(en, `EN_RADIO_RX_CTRL_OUT)) begin
      drv[2] = '{1'b1, periph_out.radio_rx};
    end
    if (bitat(en, `EN_SPI4)) begin
      drv[3] = '{1'b1, periph_out.spi_sel4};
    end else if (bitat(en, `EN_RADIO_TX_CTRL_OUT)) begin
      drv[3] = '{1'b1, periph_out.radio_tx};
    end
    if (bitat(en, `EN_UART0_FLOW)) begin
      drv[4] = '{1'b0, 1'b0};
      drv[5] = '{1'b1, periph_out.uart0_rts};
    end else if (bitat(en, `EN_DEBUG_LO)) begin
      drv[4] = '{1'b0, 1'b0};
      drv[5] = '{1'b0, 1'b0};
    end
    if (bitat(en, `EN_UART0)) begin
      drv[6] = '{1'b1, periph_out.uart0_tx};
      drv[7] = '{1'b0, 1'b0};
    end else if (bitat(en, `EN_DEBUG_LO)) begin
      drv[6] = '{1'b1, periph_out.dbg_tdo};
      drv[7] = '{1'b0, 1'b0};
    end
    if (bitat(en, `EN_TIM0_GATE) || bitat(en, `EN_PCNT1)) begin
      drv[8] = '{1'b0, 1'b0};
    end
    if (bitat(en, `EN_TIM0_CAP) || bitat(en, `EN_SLOW_XTAL) || bitat(en, `EN_SLOW_CLK)) begin
      drv[9] = '{1'b0, 1'b0};
    end
    if (bitat(en, `EN_TIM0_PWM)) begin
      drv[10] = '{1'b1, periph_out.tim0_pwm};
    end else if (bitat(en, `EN_SLOW_XTAL)) begin
      drv[10] = '{1'b1, periph_out.xtal_out};
    end
    if (bitat(en, `EN_TIM1_GATE)) begin
      drv[11] = '{1'b0, 1'b0};
    end else if (bitat(en, `EN_TIM2_PWM)) begin
      drv[11] = '{1'b1, periph_out.tim2_pwm};
    end
    if (bitat(en, `EN_TIM1_CAP)) begin
      drv[12] = '{1'b0, 1'b0};
    end else if (bitat(en, `EN_ANT_DIV)) begin
      drv[12] = '{1'b1, periph_out.ant_div_out};
    end else if (bitat(en, `EN_AUDIO)) begin
      drv[12] = '{1'b0, 1'b0};
    end
    if (bitat(en, `EN_TIM1_PWM)) begin
      drv[13] = '{1'b1, periph_out.tim1_pwm};
    end else if (bitat(en, `EN_ANT_DIV)) begin
      drv[13] = '{1'b1, periph_out.ant_div_en};
    end else if (bitat(en, `EN_AUDIO)) begin
      drv[13] = '{1'b0, 1'b0};
    end
    // two-wire lines are open drain: enable drives low only
    if (bitat(en, `EN_TWO_WIRE)) begin
      drv[14] = '{periph_out.two_wire_clk_oe, 1'b0};
      drv[15] = '{periph_out.two_wire_data_oe, 1'b0};
    end else if (bitat(en, `EN_SLAVE_PORT)) begin
      drv[14] = '{1'b0, 1'b0};
      drv[15] = '{1'b1, periph_out.slave_data_out};
    end
    if (bitat(en, `EN_SLAVE_PORT)) begin
      drv[16] = '{1'b0, 1'b0};
    end
    if (bitat(en, `EN_UART1_FLOW)) begin
      drv[17] = '{1'b0, 1'b0};
      drv[18] = '{1'b1, periph_out.uart1_rts};
    end else if (bitat(en, `EN_SLAVE_PORT)) begin
      drv[17] = '{1'b0, 1'b0};
      drv[18] = '{1'b1, periph_out.slave_irq};
    end else if (bitat(en, `EN_AUDIO)) begin
      drv[17] = '{1'b0, 1'b0};
      drv[18] = '{1'b1, periph_out.audio_data_out};
    end else if (bitat(en, `EN_DEBUG_HI)) begin
      drv[17] = '{1'b0, 1'b0};
      drv[18] = '{1'b0, 1'b0};
    end
    if (bitat(en, `EN_UART1)) begin
      drv[19] = '{1'b1, periph_out.uart1_tx};
      drv[20] = '{1'b0, 1'b0};
    end else if (bitat(en, `EN_DEBUG_HI)) begin
      drv[19] = '{1'b1, periph_out.dbg_tdo};
      drv[20] = '{1'b0, 1'b0};
    end
  end

  always_comb begin
    next_s = s;
    next_s.din_s1 = gen_io_pin_in;
    next_s.din_s2 = s.din_s1;
    next_s.rst_pin_low = 1'b0;
    next_s.wake = 1'b0;
    next_s.pready = 1'b0;
    next_s.pslverr = 1'b0;
    // one wait state: answer in the cycle after the access phase starts
    if (access && !s.pready) begin
      next_s.pready = 1'b1;
      next_s.prdata = 32'h0000_0000;
      unique case (paddr)
        `REG_DOUT: begin
          if (pwrite) next_s.dout = pwdata[`NPINS-1:0];
          next_s.prdata = {11'h000, s.dout};
        end
        `REG_DIR: begin
          if (pwrite) next_s.dir = pwdata[`NPINS-1:0];
          next_s.prdata = {11'h000, s.dir};
        end
        `REG_PULL: begin
          if (pwrite) next_s.pull = pwdata[`NPINS-1:0];
          next_s.prdata = {11'h000, s.pull};
        end
        `REG_DIN: next_s.prdata = {11'h000, s.din_s2};
        `REG_PERIPH: begin
          if (pwrite) next_s.periph_en = pwdata[26:0];
          next_s.prdata = {5'h00, s.periph_en};
        end
        `REG_WAKE_EN: begin
          if (pwrite) next_s.wake_en = pwdata[`NPINS-1:0];
          next_s.prdata = {11'h000, s.wake_en};
        end
        `REG_CTRL: begin
          if (pwrite) begin
            next_s.sleep = pwdata[`CTRL_SLEEP];
            next_s.soft_reset = pwdata[`CTRL_SOFT_RESET];
          end
          next_s.prdata = {30'h0000_0000, s.soft_reset, s.sleep};
        end
        default: next_s.pslverr = 1'b1;
      endcase
    end
    if (!wr && s.soft_reset) next_s.soft_reset = 1'b0;
    next_s.rst_pin_low = s.soft_reset;
    // wake from any input pin that reads low with its wake enable set, or external request
    if (s.sleep && ((s.wake_en & ~s.hold_oe & ~s.din_s2) != '0 || wake_req_in)) begin
      next_s.sleep = 1'b0;
      next_s.wake = 1'b1;
    end
    for (int i = 0; i < `NPINS; i++) begin
      if (!s.sleep) begin
        next_s.hold_oe[i] = drv[i].oe;
        next_s.hold_out[i] = drv[i].dout;
      end
    end
    if (s.sleep) begin
      next_s.pin_oe = s.hold_oe;
      next_s.pin_out = s.hold_out;
    end else begin
      for (int i = 0; i < `NPINS; i++) begin
        next_s.pin_oe[i] = drv[i].oe;
        next_s.pin_out[i] = drv[i].dout;
      end
    end
    next_s.pin_to_periph = '{s.din_s2[1], s.din_s2[8], s.din_s2[4], s.din_s2[7],
      s.din_s2[17], s.din_s2[20], en[`EN_DEBUG_HI] ? s.din_s2[17] : s.din_s2[4],
      en[`EN_DEBUG_HI] ? s.din_s2[18] : s.din_s2[5],
      en[`EN_DEBUG_HI] ? s.din_s2[20] : s.din_s2[7],
      s.din_s2[8], s.din_s2[9], s.din_s2[11], s.din_s2[12], s.din_s2[9], s.din_s2[9],
      s.din_s2[12], s.din_s2[13], s.din_s2[17], s.din_s2[14], s.din_s2[15],
      s.din_s2[14], s.din_s2[16], s.din_s2[17]};
    if (!rst_b) begin
      next_s = '0;
      next_s.pull = `PULL_RESET;
      next_s.rst_pin_low = 1'b1;
    end
  end

  always_ff @(posedge mclk) begin
    s <= next_s;
  end

  assign prdata = s.prdata;
  assign pready = s.pready;
  assign pslverr = s.pslverr;
  assign gen_io_pin_out = s.pin_out;
  assign gen_io_pin_oe = s.pin_oe;
  assign gen_io_pin_pullup = s.pull;
  assign periph_in = s.pin_to_periph;
  assign sleep_active = s.sleep;
  assign wake_event = s.wake;
  assign reset_pin_low_oe = s.rst_pin_low;

  a_reset_pins_float: assert property (@(posedge mclk) !rst_b |=> gen_io_pin_oe == '0)
    else $error("pins driven after reset");
  a_reset_pull_on: assert property (@(posedge mclk) !rst_b |=> gen_io_pin_pullup == 21'h1FFFFF)
    else $error("pull-ups not enabled after reset");
  a_sleep_hold_pins: assert property (@(posedge mclk) disable iff (!rst_b)
    sleep_active && $past(sleep_active) |-> $stable(gen_io_pin_oe) && $stable(gen_io_pin_out))
    else $error("pins changed during sleep");
  a_wake_clears_sleep: assert property (@(posedge mclk) disable iff (!rst_b)
    wake_event |-> !sleep_active && $past(sleep_active))
    else $error("wake without sleep");
  a_reset_pin_drive: assert property (@(posedge mclk) disable iff (!rst_b)
    s.soft_reset |=> reset_pin_low_oe)
    else $error("internal reset not on pin");
  a_spi4_takes_pin: assert property (@(posedge mclk) disable iff (!rst_b)
    en[`EN_SPI4] && !sleep_active && !s.sleep ##1 !sleep_active |-> gen_io_pin_oe[3])
    else $error("pin 3 not driven by spi select");
  a_uart0_tx_pin: assert property (@(posedge mclk) disable iff (!rst_b)
    en[`EN_UART0] && !s.sleep |=> s.sleep || gen_io_pin_oe[6])
    else $error("pin 6 not driven by uart0");
  a_gate_in_pin: assert property (@(posedge mclk) disable iff (!rst_b)
    en[`EN_TIM0_GATE] && !s.sleep |=> s.sleep || !gen_io_pin_oe[8])
    else $error("pin 8 driven while input");
  a_pin_gpio_follow: assert property (@(posedge mclk) disable iff (!rst_b)
    en == '0 && !s.sleep |=> s.sleep || gen_io_pin_oe == $past(s.dir))
    else $error("gpio direction not followed");
  a_apb_one_wait: assert property (@(posedge mclk) disable iff (!rst_b)
    psel && penable && !pready |=> pready)
    else $error("apb answer late");
endmodule
`default_nettype wire

/* dv/pin_world.sv */
// Purpose: pin-side world for the pin multiplexer: external drivers, pull-ups, reset line
// Assumes: one clock mclk; external circuits only drive pins the bench enables
// Notes: an undriven pin without pull-up toggles each cycle instead of holding a value
`timescale 1ns/100ps
`default_nettype none
module pin_world (
  input wire logic mclk,
  input wire pin_mux_pkg::pin_vec_t drv_out,
  input wire pin_mux_pkg::pin_vec_t drv_oe,
  input wire pin_mux_pkg::pin_vec_t pull_en,
  input wire pin_mux_pkg::pin_vec_t ext_val,
  input wire pin_mux_pkg::pin_vec_t ext_oe,
  input wire logic rst_oe,
  input wire logic ext_rst_low,
  output pin_mux_pkg::pin_vec_t level,
  output logic rst_level
);
  pin_mux_pkg::pin_vec_t last = '0;
  always_comb begin
    for (int i = 0; i < $bits(level); i++) begin
      if (drv_oe[i]) begin
        level[i] = drv_out[i];
      end else if (ext_oe[i]) begin
        level[i] = ext_val[i];
      end else if (pull_en[i]) begin
        level[i] = 1'b1;
      end else begin
        level[i] = ~last[i];
      end
    end
  end
  always @(posedge mclk) begin
    last <= level;
  end
  // pulled up unless either side pulls it low
  assign rst_level = ~(rst_oe | ext_rst_low);
endmodule
`default_nettype wire

/* dv/digital_io_pin_mux_bench.sv */
// Purpose: self-checking bench for the pin multiplexer
// Assumes: APB answer after one wait state; pins follow registers one cycle later
// Notes: peripheral outputs are all ones so a routed output shows as a driven high
`timescale 1ns/100ps
`default_nettype none
`include "pin_mux_cfg.svh"
`define CHK(g, e) begin total_checks++; if ((g) !== (e)) begin mismatches++; \
  $display("BAD t=%0t got=%h exp=%h", $time, (g), (e)); end end
module digital_io_pin_mux_bench;
  logic mclk = 1'b0;
  logic rst_b = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h00000000;
  logic [31:0] prdata;
  logic pready, pslverr, sleep_active, wake_event, rst_oe, rst_level, err;
  logic wake_req_in = 1'b0;
  logic [31:0] rd;
  pin_mux_pkg::pin_vec_t pin_lvl, pout, poe, pup;
  pin_mux_pkg::pin_vec_t ext_val = 21'h000000;
  pin_mux_pkg::pin_vec_t ext_oe = 21'h1FFFFF;
  pin_mux_pkg::periph_out_t pdrv = '1;
  pin_mux_pkg::periph_in_t p_in;
  int mismatches = 0;
  int total_checks = 0;
  always #10 mclk = ~mclk;
  pin_mux i_pin_mux (.mclk, .rst_b, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
    .pready, .pslverr, .gen_io_pin_in(pin_lvl), .gen_io_pin_out(pout),
    .gen_io_pin_oe(poe), .gen_io_pin_pullup(pup), .periph_out(pdrv), .periph_in(p_in),
    .wake_req_in, .sleep_active, .wake_event, .reset_pin_low_in(rst_level),
    .reset_pin_low_oe(rst_oe));
  pin_world i_pin_world (.mclk, .drv_out(pout), .drv_oe(poe), .pull_en(pup), .ext_val,
    .ext_oe, .rst_oe, .ext_rst_low(1'b0), .level(pin_lvl), .rst_level);
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge mclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge mclk);
    penable <= 1'b1;
    // pready and prdata are read in the edge's active region, before the design updates
    do begin
      @(posedge mclk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    if (n >= 50) mismatches++;
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic settle(input int n);
    repeat (n) @(posedge mclk);
    #1;
  endtask
  task automatic t_reset();
    repeat (4) @(posedge mclk);
    #1;
    `CHK(poe, 21'h000000)
    `CHK(pup, 21'h1FFFFF)
    `CHK(rst_level, 1'b0)
    @(posedge mclk);
    rst_b <= 1'b1;
    apb(1'b0, `REG_PULL, 32'h00000000);
    `CHK(rd, 32'h001FFFFF)
    `CHK(rst_oe, 1'b0)
  endtask
  task automatic t_gpio();
    ext_oe <= 21'h1FFF00;
    ext_val <= 21'h0A5A5A;
    apb(1'b1, `REG_DIR, 32'h000000FF);
    apb(1'b1, `REG_DOUT, 32'h0000003C);
    settle(2);
    `CHK(poe, 21'h0000FF)
    `CHK(pout[7:0], 8'h3C)
    settle(3);
    apb(1'b0, `REG_DIN, 32'h00000000);
    `CHK(rd, 32'h000A5A3C)
    apb(1'b1, `REG_DIR, 32'h00000000);
    ext_oe <= 21'h1FFFFF;
  endtask
  task automatic t_pull();
    apb(1'b1, `REG_PULL, 32'h0000000F);
    apb(1'b1, `REG_PERIPH, 32'h1 << `EN_UART0);
    settle(2);
    `CHK(pup, 21'h00000F)
    apb(1'b0, `REG_PULL, 32'h00000000);
    `CHK(rd, 32'h0000000F)
    apb(1'b1, `REG_PULL, 32'h001FFFFF);
  endtask
  task automatic t_route();
    int bits[11] = '{`EN_SPI1, `EN_SPI4, `EN_RADIO_TX_CTRL_OUT, `EN_UART0, `EN_UART0_FLOW, `EN_TIM0_PWM,
      `EN_TIM2_PWM, `EN_UART1, `EN_SLAVE_PORT, `EN_DEBUG_HI, `EN_DEBUG_LO};
    int pins[11] = '{0, 3, 3, 6, 5, 10, 11, 19, 15, 19, 6};
    for (int i = 0; i < 11; i++) begin
      apb(1'b1, `REG_PERIPH, 32'h1 << bits[i]);
      settle(2);
      `CHK(poe[pins[i]], 1'b1)
      `CHK(pout[pins[i]], 1'b1)
    end
  endtask
  task automatic t_prio();
    pdrv.spi_sel4 <= 1'b0;
    apb(1'b1, `REG_PERIPH, (32'h1 << `EN_SPI4) | (32'h1 << `EN_RADIO_TX_CTRL_OUT));
    settle(2);
    `CHK(pout[3], 1'b0)
    apb(1'b1, `REG_PERIPH, 32'h00000000);
    settle(2);
    `CHK(poe[3], 1'b0)
    pdrv <= '1;
  endtask
  task automatic t_input();
    apb(1'b1, `REG_PERIPH, (32'h1 << `EN_TIM0_GATE) | (32'h1 << `EN_UART0));
    for (int v = 1; v >= 0; v--) begin
      ext_val <= 21'(v) << 8;
      settle(6);
      `CHK(p_in.tim0_gate, 1'(v))
      `CHK(poe[8], 1'b0)
      `CHK(poe[7], 1'b0)
    end
    apb(1'b1, `REG_PERIPH, 32'h00000000);
  endtask
  task automatic t_sleep();
    int n;
    n = 0;
    ext_val <= 21'h000004;
    apb(1'b1, `REG_DIR, 32'h00000001);
    apb(1'b1, `REG_DOUT, 32'h00000001);
    apb(1'b1, `REG_WAKE_EN, 32'h00000004);
    apb(1'b1, `REG_CTRL, 32'h00000001);
    settle(2);
    `CHK(sleep_active, 1'b1)
    apb(1'b1, `REG_DOUT, 32'h00000000);
    apb(1'b1, `REG_DIR, 32'h00000000);
    settle(2);
    `CHK(poe[0], 1'b1)
    `CHK(pout[0], 1'b1)
    ext_val <= 21'h000000;
    while (wake_event !== 1'b1 && n < 10) begin
      settle(1);
      n++;
    end
    `CHK(wake_event, 1'b1)
    settle(1);
    `CHK(sleep_active, 1'b0)
  endtask
  task automatic t_misc();
    int n;
    n = 0;
    apb(1'b0, 12'h0FC, 32'h00000000);
    `CHK(err, 1'b1)
    apb(1'b1, `REG_CTRL, 32'h00000002);
    while (rst_oe !== 1'b1 && n < 10) begin
      settle(1);
      n++;
    end
    `CHK(rst_level, 1'b0)
  endtask
  task automatic give_verdict();
    $display("mismatches=%0d total_checks=%0d", mismatches, total_checks);
    if (mismatches == 0 && total_checks > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  initial begin
    t_reset();
    t_gpio();
    t_pull();
    t_route();
    t_prio();
    t_input();
    t_sleep();
    t_misc();
    give_verdict();
  end
  // whole run takes well under a thousand cycles
  initial begin
    #100000;
    mismatches++;
    give_verdict();
  end
endmodule
`default_nettype wire
